// ### cpd_cmd_decode.sv
`timescale 1ns/1ps
`include "cpd_cfg.svh"

module cpd_cmd_decode (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// command word from host software
	input  wire logic                     cmd_valid,
	input  wire logic [`CPD_WORD_W-1:0]   cmd_word,
	output logic                          cmd_ready,
	// decoded command to the execution side
	output logic                          dec_valid,
	output cpd_pkg::cpd_dec_t             dec,
	input  wire logic                     dec_ready,
	// status
	output logic                          busy,
	output logic                          su_clr_pulse,
	// signal unit path through the filter
	input  wire logic                     filt_en,
	input  wire logic                     su_in_valid,
	input  wire logic [`CPD_SU_W-1:0]     su_in_data,
	output logic                          su_out_valid,
	output logic [`CPD_SU_W-1:0]          su_out_data
);
	import cpd_pkg::*;

	cpd_state_t                 state_ff;
	cpd_state_t                 nxt_state;
	logic [`CPD_WORD_W-1:0]     word_ff;
	logic [`CPD_WORD_W-1:0]     nxt_word;
	cpd_dec_t                   dec_ff;
	cpd_dec_t                   nxt_dec;
	logic                       su_clr_ff;
	logic                       nxt_su_clr;

	// raw fields of the held word
	logic [`CPD_SBC_W-1:0]      f_sbc;
	logic [`CPD_PCODE_W-1:0]    f_pcode;
	logic [`CPD_EP_W-1:0]       f_ep;
	logic [`CPD_OPC_W-1:0]      f_opc;
	cpd_target_t                tgt;
	logic                       pcode_ok;
	logic                       issue_done;

	// field extraction from the held word
	assign f_sbc   = word_ff[`CPD_SBC_MSB:`CPD_SBC_LSB];
	assign f_pcode = word_ff[`CPD_PCODE_MSB:`CPD_PCODE_LSB];
	assign f_ep    = word_ff[`CPD_EP_MSB:`CPD_EP_LSB];
	assign f_opc   = word_ff[`CPD_OPC_MSB:`CPD_OPC_LSB];

	// controller select; unknown sub-block codes fall into other
	always_comb begin
		case (f_sbc)
			`CPD_SBC_FSC: tgt = CPD_TGT_FSC;
			`CPD_SBC_MCC: tgt = CPD_TGT_MCC;
			`CPD_SBC_USB: tgt = CPD_TGT_USB;
			default:      tgt = CPD_TGT_OTHER;
		endcase
	end

	// only the four listed protocol codes are legal on a channel
	always_comb begin
		case (f_pcode)
			`CPD_PCODE_HDLC:   pcode_ok = 1'b1;
			`CPD_PCODE_ATM:    pcode_ok = 1'b1;
			`CPD_PCODE_ETH:    pcode_ok = 1'b1;
			`CPD_PCODE_TRANSP: pcode_ok = 1'b1;
			default:           pcode_ok = 1'b0;
		endcase
	end

	assign issue_done = (state_ff == CPD_ST_ISSUE) && dec_ready;

	// sequencing: take a word, decode it one cycle, offer it until taken;
	// a single word in flight keeps the decode free of any buffering
	always_comb begin
		nxt_state  = state_ff;
		nxt_word   = word_ff;
		nxt_dec    = dec_ff;
		nxt_su_clr = 1'b0;
		case (state_ff)
			CPD_ST_IDLE: begin
				if (cmd_valid) begin
					nxt_word  = cmd_word;
					nxt_state = CPD_ST_DECODE;
				end
			end
			CPD_ST_DECODE: begin
				nxt_dec.target    = tgt;
				nxt_dec.opcode    = f_opc;
				// protocol code only means something on a channel
				nxt_dec.proto     = (tgt == CPD_TGT_FSC) ?
				                    f_pcode : `CPD_PCODE_HDLC;
				nxt_dec.proto_err = (tgt == CPD_TGT_FSC) && !pcode_ok;
				// endpoint forced to zero outside usb commands
				nxt_dec.endpoint  = (tgt == CPD_TGT_USB) ?
				                    f_ep : `CPD_EP_NONE;
				nxt_dec.su_clear  = (tgt == CPD_TGT_MCC) &&
				                    (f_opc == `CPD_OPC_SU_CLR);
				nxt_state         = CPD_ST_ISSUE;
			end
			CPD_ST_ISSUE: begin
				if (dec_ready) begin
					// every clear pulses again, so repeats keep working
					nxt_su_clr = dec_ff.su_clear;
					nxt_state  = CPD_ST_IDLE;
				end
			end
			default: begin
				nxt_state = CPD_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff  <= CPD_ST_IDLE;
			word_ff   <= `CPD_WORD_RST;
			dec_ff    <= '0;
			su_clr_ff <= 1'b0;
		end else begin
			state_ff  <= nxt_state;
			word_ff   <= nxt_word;
			dec_ff    <= nxt_dec;
			su_clr_ff <= nxt_su_clr;
		end
	end

	// handshake outputs
	assign cmd_ready    = (state_ff == CPD_ST_IDLE);
	assign dec_valid    = (state_ff == CPD_ST_ISSUE);
	assign busy         = (state_ff != CPD_ST_IDLE);
	assign dec          = dec_ff;
	assign su_clr_pulse = su_clr_ff;

	// signal unit filter, cleared by the decoded command
	cpd_su_filter u_su_filter (
		.clk       (clk),
		.rst_n     (rst_n),
		.filt_en   (filt_en),
		.clear     (su_clr_ff),
		.in_valid  (su_in_valid),
		.in_data   (su_in_data),
		.out_valid (su_out_valid),
		.out_data  (su_out_data)
	);

	// a command walks idle, decode, issue in consecutive cycles
	sequence s_taken;
		cmd_valid && cmd_ready;
	endsequence

	sequence s_walk;
		state_ff == CPD_ST_DECODE ##1 dec_valid;
	endsequence

	chk_cmd_walk: assert property (
		@(posedge clk) disable iff (!rst_n)
		s_taken |=> s_walk)
		else $error("command did not reach issue two cycles after take");

	chk_legal_code_ok: assert property (
		@(posedge clk) disable iff (!rst_n)
		dec_valid && dec.target == CPD_TGT_FSC &&
		(dec.proto == `CPD_PCODE_HDLC || dec.proto == `CPD_PCODE_ATM ||
		 dec.proto == `CPD_PCODE_ETH || dec.proto == `CPD_PCODE_TRANSP)
		|-> !dec.proto_err)
		else $error("legal protocol code flagged as error");

	chk_proto_passed: assert property (
		@(posedge clk) disable iff (!rst_n)
		state_ff == CPD_ST_DECODE && tgt == CPD_TGT_FSC
		|=> dec.proto == $past(f_pcode) &&
		    dec.proto_err == !$past(pcode_ok))
		else $error("protocol code not carried to the decoded command");

	chk_endpoint_pass: assert property (
		@(posedge clk) disable iff (!rst_n)
		state_ff == CPD_ST_DECODE && tgt == CPD_TGT_USB
		|=> dec.endpoint == $past(f_ep))
		else $error("usb endpoint not carried to the decoded command");

	chk_endpoint_mask: assert property (
		@(posedge clk) disable iff (!rst_n)
		dec_valid && dec.target != CPD_TGT_USB |-> dec.endpoint == '0)
		else $error("endpoint leaked on a non-usb command");

	chk_su_clr_pulse: assert property (
		@(posedge clk) disable iff (!rst_n)
		issue_done && dec.su_clear |=> su_clr_pulse ##1 !su_clr_pulse)
		else $error("filter clear pulse missing or too long");

	chk_su_clr_cause: assert property (
		@(posedge clk) disable iff (!rst_n)
		su_clr_pulse |-> $past(issue_done) &&
		$past(dec.target) == CPD_TGT_MCC &&
		$past(dec.opcode) == `CPD_OPC_SU_CLR)
		else $error("filter clear without its opcode");

	chk_hold_offer: assert property (
		@(posedge clk) disable iff (!rst_n)
		dec_valid && !dec_ready |=> dec_valid && $stable(dec))
		else $error("decoded command dropped before it was taken");

	chk_ready_busy: assert property (
		@(posedge clk) disable iff (!rst_n)
		cmd_ready != busy)
		else $error("ready and busy disagree");

endmodule // cpd_cmd_decode

// ### cpd_cfg.svh
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH

// command word field positions, bit 0 of the word is the lsb here
`define CPD_OPC_MSB        3
`define CPD_OPC_LSB        0
`define CPD_EP_MSB         5
`define CPD_EP_LSB         4
`define CPD_PCODE_MSB      13
`define CPD_PCODE_LSB      6
`define CPD_SBC_MSB        25
`define CPD_SBC_LSB        21

// widths
`define CPD_WORD_W         32
`define CPD_OPC_W          4
`define CPD_EP_W           2
`define CPD_PCODE_W        8
`define CPD_SBC_W          5
`define CPD_SU_W           16

// sub-block codes of the addressed controller
`define CPD_SBC_FSC        5'h10
`define CPD_SBC_MCC        5'h1c
`define CPD_SBC_USB        5'h13

// opcodes
`define CPD_OPC_SU_CLR     4'he

// protocol codes of the fast serial channel
`define CPD_PCODE_HDLC     8'h00
`define CPD_PCODE_ATM      8'h0a
`define CPD_PCODE_ETH      8'h0c
`define CPD_PCODE_TRANSP   8'h0f

// reset values
`define CPD_WORD_RST       32'h0000_0000
`define CPD_SU_RST         16'h0000
`define CPD_EP_NONE        2'h0

`endif

// ### cpd_pkg.sv
`include "cpd_cfg.svh"

package cpd_pkg;

	// controller that a command word addresses
	typedef enum logic [1:0] {
		CPD_TGT_FSC   = 2'b00,
		CPD_TGT_MCC   = 2'b01,
		CPD_TGT_USB   = 2'b10,
		CPD_TGT_OTHER = 2'b11
	} cpd_target_t;

	// protocol run by a fast serial channel
	typedef enum logic [`CPD_PCODE_W-1:0] {
		CPD_PROTO_HDLC   = `CPD_PCODE_HDLC,
		CPD_PROTO_ATM    = `CPD_PCODE_ATM,
		CPD_PROTO_ETH    = `CPD_PCODE_ETH,
		CPD_PROTO_TRANSP = `CPD_PCODE_TRANSP
	} cpd_proto_t;

	// decoder sequencing
	typedef enum logic [1:0] {
		CPD_ST_IDLE   = 2'b00,
		CPD_ST_DECODE = 2'b01,
		CPD_ST_ISSUE  = 2'b10
	} cpd_state_t;

	// decoded command handed to the execution side
	typedef struct packed {
		cpd_target_t                target;
		logic [`CPD_PCODE_W-1:0]    proto;
		logic [`CPD_EP_W-1:0]       endpoint;
		logic [`CPD_OPC_W-1:0]      opcode;
		logic                       su_clear;
		logic                       proto_err;
	} cpd_dec_t;

endpackage

// ### cpd_su_filter.sv
`timescale 1ns/1ps
`include "cpd_cfg.svh"

module cpd_su_filter (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// control
	input  wire logic                   filt_en,
	input  wire logic                   clear,
	// received signal units
	input  wire logic                   in_valid,
	input  wire logic [`CPD_SU_W-1:0]   in_data,
	// accepted signal units
	output logic                        out_valid,
	output logic [`CPD_SU_W-1:0]        out_data
);
	import cpd_pkg::*;

	logic                   primed_ff;
	logic                   nxt_primed;
	logic [`CPD_SU_W-1:0]   last_ff;
	logic [`CPD_SU_W-1:0]   nxt_last;
	logic                   out_valid_ff;
	logic                   nxt_out_valid;
	logic [`CPD_SU_W-1:0]   out_data_ff;
	logic [`CPD_SU_W-1:0]   nxt_out_data;
	logic                   drop;

	// a repeat of the last accepted unit is dropped; a clear in the same
	// cycle as a unit unprimes first, so that very unit gets through
	always_comb begin
		drop          = filt_en && primed_ff && !clear && (in_data == last_ff);
		nxt_primed    = clear ? 1'b0 : primed_ff;
		nxt_last      = last_ff;
		nxt_out_valid = 1'b0;
		nxt_out_data  = out_data_ff;
		if (in_valid && !drop) begin
			nxt_primed    = 1'b1;
			nxt_last      = in_data;
			nxt_out_valid = 1'b1;
			nxt_out_data  = in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			primed_ff    <= 1'b0;
			last_ff      <= `CPD_SU_RST;
			out_valid_ff <= 1'b0;
			out_data_ff  <= `CPD_SU_RST;
		end else begin
			primed_ff    <= nxt_primed;
			last_ff      <= nxt_last;
			out_valid_ff <= nxt_out_valid;
			out_data_ff  <= nxt_out_data;
		end
	end

	assign out_valid = out_valid_ff;
	assign out_data  = out_data_ff;

	chk_clear_accepts_next: assert property (
		@(posedge clk) disable iff (!rst_n)
		clear && in_valid |=> out_valid && out_data == $past(in_data))
		else $error("unit after filter clear was not accepted");

	// a cleared or freshly reset filter must pass whatever comes next
	chk_unprimed_pass: assert property (
		@(posedge clk) disable iff (!rst_n)
		!primed_ff && in_valid |=> out_valid && out_data == $past(in_data))
		else $error("unit reaching an unprimed filter was not accepted");

	chk_repeat_dropped: assert property (
		@(posedge clk) disable iff (!rst_n)
		filt_en && primed_ff && in_valid && !clear && in_data == last_ff
		|=> !out_valid)
		else $error("repeated signal unit was not filtered");

endmodule // cpd_su_filter

// ### cpd_cmd_decode_tb_top.sv
`timescale 1ns/1ps
`include "cpd_cfg.svh"

module cpd_cmd_decode_tb_top;
	import cpd_pkg::*;

	logic                  clk;
	logic                  rst_n;
	logic                  cmd_valid;
	logic [`CPD_WORD_W-1:0] cmd_word;
	logic                  cmd_ready;
	logic                  dec_valid;
	cpd_dec_t              dec;
	logic                  dec_ready;
	logic                  busy;
	logic                  su_clr_pulse;
	logic                  filt_en;
	logic                  su_in_valid;
	logic [`CPD_SU_W-1:0]  su_in_data;
	logic                  su_out_valid;
	logic [`CPD_SU_W-1:0]  su_out_data;
	int                    errors;
	int                    check_count;
	cpd_dec_t              dq[$];
	logic [`CPD_SU_W-1:0]  uq[$];
	bit                    pend;

	cpd_cmd_decode uut (
		.clk          (clk),
		.rst_n        (rst_n),
		.cmd_valid    (cmd_valid),
		.cmd_word     (cmd_word),
		.cmd_ready    (cmd_ready),
		.dec_valid    (dec_valid),
		.dec          (dec),
		.dec_ready    (dec_ready),
		.busy         (busy),
		.su_clr_pulse (su_clr_pulse),
		.filt_en      (filt_en),
		.su_in_valid  (su_in_valid),
		.su_in_data   (su_in_data),
		.su_out_valid (su_out_valid),
		.su_out_data  (su_out_data)
	);

	// free running 100 MHz clock
	initial clk = 1'b0;
	always #5 clk = ~clk;

	task bad(input string m);
		errors++;
		$display("BAD %0t %s", $time, m);
	endtask

	task results;
		if (errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// compare tasks, one per kind of result
	task cmp_dec(input cpd_dec_t e, input cpd_dec_t g);
		check_count++;
		if (g !== e) bad("decoded command differs");
	endtask

	task cmp_su(input logic [`CPD_SU_W-1:0] e, input logic [`CPD_SU_W-1:0] g);
		check_count++;
		if (g !== e) bad("accepted unit differs");
	endtask

	task cmp_pulse(input logic e, input logic g);
		check_count++;
		if (g !== e) bad("filter clear pulse wrong");
	endtask

	// expected decode worked out from the field map
	function cpd_dec_t exp_of(input logic [31:0] w);
		cpd_dec_t e;
		e = '0;
		e.opcode = w[3:0];
		case (w[25:21])
			`CPD_SBC_FSC: e.target = CPD_TGT_FSC;
			`CPD_SBC_MCC: e.target = CPD_TGT_MCC;
			`CPD_SBC_USB: e.target = CPD_TGT_USB;
			default:      e.target = CPD_TGT_OTHER;
		endcase
		if (e.target == CPD_TGT_FSC) begin
			e.proto = w[13:6];
			e.proto_err = !(w[13:6] inside {8'h00, 8'h0a, 8'h0c, 8'h0f});
		end
		if (e.target == CPD_TGT_USB) e.endpoint = w[5:4];
		e.su_clear = (e.target == CPD_TGT_MCC) && (w[3:0] == 4'he);
		return e;
	endfunction

	// unused bits are random so the decoder must mask them
	function logic [31:0] mk(input logic [4:0] s, input logic [1:0] ep,
			input logic [7:0] pc, input logic [3:0] op);
		mk = $urandom;
		mk[25:21] = s;
		mk[13:6] = pc;
		mk[5:4] = ep;
		mk[3:0] = op;
	endfunction

	// word is held while refused, dropped at the taking edge
	task send_cmd(input logic [31:0] w);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_word <= w;
		forever begin
			@(posedge clk);
			if (cmd_ready) break;
		end
		cmd_valid <= 1'b0;
		dq.push_back(exp_of(w));
	endtask

	// returns at the edge that ends the cycle carrying the clear pulse
	task wait_idle;
		int n;
		@(posedge clk);
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			if (busy === 1'b0) break;
		end
		if (n == 60) bad("decoder stuck busy");
	endtask

	task su(input logic [`CPD_SU_W-1:0] d, input bit acc);
		@(posedge clk);
		su_in_valid <= 1'b1;
		su_in_data <= d;
		if (acc) uq.push_back(d);
	endtask

	task su_end;
		@(posedge clk);
		su_in_valid <= 1'b0;
	endtask

	// execution side stalls at random to stretch the handshake
	always @(posedge clk) dec_ready <= ($urandom_range(0, 3) != 0);

	// watcher: takes the oldest note whenever a result shows
	always @(posedge clk) begin
		if (rst_n) begin
			cmp_pulse(pend, su_clr_pulse);
			pend = 1'b0;
			if (dec_valid && dec_ready) begin
				if (dq.size() == 0) bad("decode with no command");
				else begin
					pend = dq[0].su_clear;
					cmp_dec(dq.pop_front(), dec);
				end
			end
			if (su_out_valid) begin
				if (uq.size() == 0) bad("unit passed the filter");
				else cmp_su(uq.pop_front(), su_out_data);
			end
		end
	end

	// watchdog sized well above the expected run
	initial begin
		repeat (5000) @(posedge clk);
		bad("watchdog expired");
		results;
	end

	// main sequence
	initial begin
		logic [4:0]           sb[4];
		logic [7:0]           pcs[4];
		logic [`CPD_SU_W-1:0] a;
		logic [31:0]          clr;
		void'($urandom(34622));
		sb = '{`CPD_SBC_FSC, `CPD_SBC_MCC, `CPD_SBC_USB, 5'h01};
		pcs = '{`CPD_PCODE_HDLC, `CPD_PCODE_ATM, `CPD_PCODE_ETH,
			`CPD_PCODE_TRANSP};
		errors = 0;
		check_count = 0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_word = '0;
		filt_en = 1'b0;
		su_in_valid = 1'b0;
		su_in_data = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		a = `CPD_SU_W'($urandom);
		clr = mk(`CPD_SBC_MCC, 2'h3, 8'h00, `CPD_OPC_SU_CLR);
		// unprimed after reset, repeats pass while filtering is off
		su(a, 1);
		su(a, 1);
		su_end;
		@(posedge clk);
		filt_en <= 1'b1;
		su(a ^ 16'h0001, 1);
		su(a ^ 16'h0001, 0);
		su(~a, 1);
		su(~a, 0);
		su_end;
		send_cmd(clr);
		wait_idle;
		su(~a, 1);
		su_end;
		send_cmd(clr);
		wait_idle;
		send_cmd(clr);
		wait_idle;
		su(~a, 1);
		su(~a, 0);
		su_end;
		// repeats stream through a clear; only the unit in its cycle passes
		su(~a, 1);
		send_cmd(clr);
		wait_idle;
		su_end;
		filt_en <= 1'b0;
		// every target with each of the four listed protocol codes, one random code, and every endpoint
		for (int t = 0; t < 4; t++) begin
			for (int k = 0; k < 5; k++) begin
				send_cmd(mk(sb[t], 2'(k), (k < 4) ? pcs[k] : 8'($urandom),
					(k == 1) ? 4'he : 4'($urandom)));
			end
		end
		wait_idle;
		// mid-run reset: the filter restarts unprimed, so a zero unit passes
		rst_n <= 1'b0;
		filt_en <= 1'b1;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		su('0, 1);
		su('0, 0);
		su_end;
		send_cmd(clr);
		wait_idle;
		repeat (5) @(posedge clk);
		if (dq.size() != 0 || uq.size() != 0) bad("results missing");
		results;
	end

endmodule // cpd_cmd_decode_tb_top
